// file: design/adcsq_core.sv
// adcsq_core: successive-approximation conversion sequencer
// assumes the comparator answer is valid whenever a bit is decided
`timescale 1ns/1ps
// Operation
// - trigger falling edge starts conversion, busy high
// - busy stays high until conversion completes
// - trigger fall resets the approximation register first
// - quick trigger rise suppresses internal bit clock
// - resolution plus one external pulses complete one conversion, seventeen at 16 bits
// - busy high after first pulse, low after the last (the seventeenth at 16 bits)
// - output coding is complementary binary
// - short cycle ends right after last bit
module adcsq_core #(
  parameter int unsigned RES = adcsq_pkg::RES_BITS
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // trigger, active low pulse
  input wire logic convert_start_n,
  // number of bits to convert, 1 to RES
  input wire logic [4:0] resolution,
  // comparator: high when input is above the trial level
  input wire logic comp_above,
  // status and data
  output logic busy,
  output logic [RES-1:0] trial,
  output logic [RES-1:0] data_out,
  output logic data_valid
);
  import adcsq_pkg::*;

  // the index arithmetic below needs at least two bits and no more than
  // sixteen, although the five-bit resolution port could name up to 31
  if (RES < 2 || RES > 16) begin : g_bad_res
    $error("adcsq_core: RES out of range");
  end

  // a pace pulse must end before the internal bit clock could fire
  if (EXT_PULSE_MAX_CYCLES >= BIT_CYCLES) begin : g_bad_pace
    $error("adcsq_core: pace pulse limit too long");
  end

  adcsq_state_t state;
  adcsq_state_t next_state;
  logic trig_q;
  logic trig_fall;
  logic trig_rise;
  logic start;
  logic short_low;
  logic [15:0] low_cnt;
  logic [15:0] bit_cnt;
  logic bit_tick;
  logic ext_mode;
  logic [4:0] bit_idx;
  logic [4:0] last_idx;
  logic step;
  logic last_step;
  logic [RES-1:0] sar;
  logic [RES-1:0] next_sar;
  logic [RES-1:0] next_out;

  // resets high so the idle level of the pin gives no false edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trig_q <= 1'b1;
    end else begin
      trig_q <= convert_start_n;
    end
  end

  assign trig_fall = trig_q && !convert_start_n;
  assign trig_rise = !trig_q && convert_start_n;

  // falls during a conversion are not new requests
  assign start = (state == ADCSQ_IDLE) && trig_fall;

  assign last_idx = (resolution == 5'h00 || resolution > 5'(RES)) ?
    5'(RES) : resolution;

  // length of the current low phase on the trigger
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low_cnt <= 16'h0000;
    end else if (trig_fall) begin
      low_cnt <= 16'h0001;
    end else if (!convert_start_n && low_cnt != 16'hFFFF) begin
      low_cnt <= low_cnt + 16'h0001;
    end
  end

  assign short_low = (low_cnt <= 16'(EXT_PULSE_MAX_CYCLES));

  // a short low pulse marks external pacing for the rest of the conversion
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_mode <= 1'b0;
    end else if (state == ADCSQ_IDLE) begin
      ext_mode <= 1'b0;
    end else if (trig_rise && short_low) begin
      ext_mode <= 1'b1;
    end
  end

  // internal bit clock; held at zero once external pulses take over
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt <= 16'h0000;
    end else if (state != ADCSQ_DECIDE || ext_mode) begin
      bit_cnt <= 16'h0000;
    end else if (bit_tick) begin
      bit_cnt <= 16'h0000;
    end else begin
      bit_cnt <= bit_cnt + 16'h0001;
    end
  end

  assign bit_tick = (bit_cnt == 16'(BIT_CYCLES - 1));

  // the first quick rise already suppresses the bit clock in its own cycle
  always_comb begin
    if (ext_mode || (trig_rise && short_low)) begin
      step = trig_fall;
    end else begin
      step = bit_tick;
    end
  end

  assign last_step = (state == ADCSQ_DECIDE) && step &&
    (bit_idx + 5'h01 == last_idx);

  always_comb begin
    next_state = state;
    case (state)
      ADCSQ_IDLE: begin
        if (trig_fall) begin
          next_state = ADCSQ_RESET;
        end
      end
      ADCSQ_RESET: begin
        next_state = ADCSQ_DECIDE;
      end
      ADCSQ_DECIDE: begin
        if (last_step) begin
          next_state = ADCSQ_IDLE;
        end
      end
      default: begin
        next_state = ADCSQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ADCSQ_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // busy drops with the last decision, in the same cycle as data_valid
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
    end else if (start) begin
      busy <= 1'b1;
    end else if (next_state == ADCSQ_IDLE) begin
      busy <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_idx <= 5'h00;
    end else if (start) begin
      bit_idx <= 5'h00;
    end else if (state == ADCSQ_DECIDE && step && !last_step) begin
      bit_idx <= bit_idx + 5'h01;
    end
  end

  // one slice per result bit; bit_idx counts up, with zero selecting the MSB
  for (genvar i = 0; i < RES; i++) begin : g_bit
    localparam logic [4:0] POS = 5'(RES - 1 - i);
    logic decide_here;
    logic trial_here;
    assign decide_here = (state == ADCSQ_DECIDE) && step &&
      (bit_idx == POS);
    assign trial_here = ((state == ADCSQ_RESET) && (POS == 5'h00)) ||
      ((state == ADCSQ_DECIDE) && step && !last_step &&
      (bit_idx + 5'h01 == POS));
    assign next_sar[i] = start ? 1'b0 :
      decide_here ? comp_above :
      trial_here ? 1'b1 : sar[i];
    // bits below a short cycle were never tried and read as ones
    assign next_out[i] = decide_here ? !comp_above : !sar[i];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sar <= '0;
    end else begin
      sar <= next_sar;
    end
  end

  // result holds until the next conversion completes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_out <= '1;
    end else if (last_step) begin
      data_out <= next_out;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_valid <= 1'b0;
    end else begin
      data_valid <= last_step;
    end
  end

  assign trial = sar;
endmodule // adcsq_core

// file: design/adcsq_pkg.sv
// adcsq_pkg: constants for the conversion sequencer
// assumes a 125 MHz system clock; all pins synchronous to it
package adcsq_pkg;
  localparam int unsigned CLK_PERIOD_PS = 8000;
  // internal bit-clock period in ns (plain default, trimmable)
  localparam int unsigned BIT_PERIOD_NS = 1000;
  localparam int unsigned BIT_CYCLES =
    (BIT_PERIOD_NS * 1000) / CLK_PERIOD_PS;
  // a trigger low no longer than this counts as an external pace pulse
  localparam int unsigned EXT_PULSE_MAX_NS = 700;
  localparam int unsigned EXT_PULSE_MAX_CYCLES =
    (EXT_PULSE_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned RES_BITS = 16;
  localparam int unsigned EXT_PULSES = 17;
  localparam logic [4:0] RES_DEFAULT = 5'h10;
  typedef enum logic [1:0] {
    ADCSQ_IDLE = 2'b00,
    ADCSQ_RESET = 2'b01,
    ADCSQ_DECIDE = 2'b11
  } adcsq_state_t;
endpackage

// file: sim/adcsq_checker.sv
// adcsq_checker: port properties of the sequencer
// assumes binding to adcsq_core, one clock domain
`timescale 1ns/1ps
module adcsq_checker #(parameter int unsigned RES = 16) (
  // clock, reset and inputs
  input wire logic clk, arst_n, convert_start_n, comp_above,
  input wire logic [4:0] resolution,
  // outputs
  input wire logic busy, data_valid,
  input wire logic [RES-1:0] trial, data_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_start; $fell(convert_start_n) && !busy |=> busy; endproperty
  a_start: assert property (p_start) else $error("no busy");
  property p_cause; $rose(busy) |-> !$past(convert_start_n); endproperty
  a_cause: assert property (p_cause) else $error("busy cause");
  property p_clear; $rose(busy) |-> trial == '0; endproperty
  a_clear: assert property (p_clear) else $error("trial set");
  property p_end; $fell(busy) |-> data_valid; endproperty
  a_end: assert property (p_end) else $error("early end");
  property p_stay; $rose(busy) |-> busy [*8]; endproperty
  a_stay: assert property (p_stay) else $error("busy short");
  property p_pulse; data_valid |=> !data_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("valid long");
  property p_done; data_valid |-> !busy && $past(busy); endproperty
  a_done: assert property (p_done) else $error("valid busy");
  property p_hold; !data_valid |-> $stable(data_out); endproperty
  a_hold: assert property (p_hold) else $error("data moved");
endmodule // adcsq_checker
bind adcsq_core adcsq_checker #(.RES(RES)) u_chk (.clk(clk),
  .arst_n(arst_n), .convert_start_n(convert_start_n),
  .comp_above(comp_above), .resolution(resolution), .busy(busy),
  .data_valid(data_valid), .trial(trial), .data_out(data_out));

// file: sim/adcsq_cmp_model.sv
// adcsq_cmp_model: ideal comparator and track-and-hold control
// assumes target is the input level as a true-binary word
`timescale 1ns/1ps
module adcsq_cmp_model (
  // controller clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // levels
  input wire logic [15:0] target,
  input wire logic [15:0] trial,
  // pins the controller sees
  input wire logic convert_start_n,
  input wire logic busy,
  // answers
  output logic comp_above,
  output logic hold
);
  logic start_q;
  logic busy_s1;
  logic busy_s2;
  logic busy_s3;
  // bit kept once the input reaches the trial level
  assign comp_above = (target >= trial);
  // busy treated as foreign: two stages before its edge is used
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      start_q <= 1'b1;
      busy_s1 <= 1'b0;
      busy_s2 <= 1'b0;
      busy_s3 <= 1'b0;
    end else begin
      start_q <= convert_start_n;
      busy_s1 <= busy;
      busy_s2 <= busy_s1;
      busy_s3 <= busy_s2;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hold <= 1'b0;
    end else if (convert_start_n && !start_q) begin
      hold <= 1'b1;
    end else if (busy_s3 && !busy_s2) begin
      hold <= 1'b0;
    end
  end
endmodule // adcsq_cmp_model

// file: sim/adcsq_core_test.sv
// adcsq_core_test: self-checking bench for the sequencer
// assumes inputs change at the falling clock edge
`timescale 1ns/1ps
module adcsq_core_test;
  logic clk = 0, arst_n = 0, start_n = 1, comp_above, busy, dv, hold;
  logic [4:0] res = 5'h10;
  logic [15:0] target = 16'h0000, trial, dout;
  int miscompares = 0, checks_done = 0, n;
  initial forever #4 clk = ~clk;
  adcsq_core u_dut (.clk(clk), .arst_n(arst_n), .convert_start_n(start_n),
    .resolution(res), .comp_above(comp_above), .busy(busy), .trial(trial),
    .data_out(dout), .data_valid(dv));
  adcsq_cmp_model u_cmp (.clk(clk), .arst_n(arst_n), .target(target),
    .trial(trial), .convert_start_n(start_n), .busy(busy),
    .comp_above(comp_above), .hold(hold));
  task cmp(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // long low phase keeps the block in internal pacing
  task conv_int(input logic [15:0] t, input logic [4:0] r);
    target = t;
    res = r;
    start_n = 0;
    n = 0;
    while (dv !== 1'b1 && n < 3000) begin
      if (n == 100) start_n = 1;
      if (n == 102) cmp({15'h0, hold}, 16'h1);
      @(negedge clk);
      n++;
    end
    cmp(16'(n / 125), {11'h0, r});
    cmp({15'h0, busy}, 16'h0);
    cmp(dout, ~(t & ~(16'hFFFF >> r)));
    repeat (3) @(negedge clk);
    cmp({15'h0, hold}, 16'h0);
  endtask
  // pulses every 55 cycles, faster than the internal bit clock
  task conv_ext(input logic [15:0] t);
    target = t;
    res = 5'h10;
    for (int i = 0; i < 17; i++) begin
      if (i > 0) cmp({15'h0, busy}, 16'h1);
      start_n = 0;
      @(negedge clk);
      cmp({15'h0, dv}, {15'h0, i == 16});
      repeat (14) @(negedge clk);
      start_n = 1;
      repeat (40) @(negedge clk);
    end
    cmp({15'h0, busy}, 16'h0);
    cmp(dout, ~t);
  endtask
  initial begin
    repeat (10) @(negedge clk);
    arst_n = 1;
    @(negedge clk);
    cmp(dout, 16'hFFFF);
    conv_int(16'h0001, 5'h10);
    conv_int(16'h8000, 5'h10);
    conv_int(16'hA5C3, 5'h08);
    conv_int(16'hFFFF, 5'h01);
    conv_ext(16'h1234);
    conv_int(16'h4321, 5'h0F);
    tally_and_finish();
  end
  initial begin
    #200us;
    miscompares++;
    tally_and_finish();
  end
endmodule // adcsq_core_test
